// ---- rtl/uart_regs.svh ----
// register offsets, field positions, reset values and timing counts for the uart block
`ifndef UART_REGS_SVH
`define UART_REGS_SVH
`define RX_CTRL_OFS       8'h00
`define RX_DATA_OFS       8'h04
`define TX_CTRL_OFS       8'h08
`define TX_DATA_OFS       8'h0C
`define IRQ_STATUS_OFS    8'h10
`define IRQ_MASK_OFS      8'h14
`define BAUD_DIV_OFS      8'h18
// control bits of rx and tx control registers; the irq source bit is tx only
`define CTL_ENABLE_BIT    0
`define CTL_PAR_EN_BIT    1
`define CTL_PAR_ODD_BIT   2
`define CTL_IRQ_SRC_BIT   3
// rx status bits (read in rx control register)
`define RX_FULL_BIT       4
`define RX_PAR_ERR_BIT    5
`define RX_FRAME_ERR_BIT  6
`define RX_OVERRUN_BIT    7
// tx status bits
`define TX_EMPTY_BIT      4
`define TX_DONE_BIT       5
// interrupt status bits
`define IRQ_RX_BIT        0
`define IRQ_TX_BIT        1
`define BAUD_DIV_RESET    16'h0014
`define TICKS_PER_BIT     3'h7
`define SAMPLE_TICK       3'h3
`endif

// ---- rtl/uart_pkg.sv ----
// types shared by the uart block
package uart_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_START  = 5'h02,
    ST_DATA   = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP   = 5'h10
  } frame_state_type;

  typedef struct packed {
    logic enable;
    logic par_en;
    logic par_odd;
    logic irq_src;
  } frame_cfg_type;
endpackage

// ---- rtl/sync2.sv ----
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module sync2 (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule // sync2

// ---- rtl/uart_rx_tx.sv ----
// uart receiver and transmitter with 8x baud tick and axi4-lite registers
// Overview of operation
// - receive 8 data bits, strip start/stop
// - rx control: enable, parity check, status
// - shift register then one byte buffer
// - rx interrupt on buffer full
// - status read clears all but full
// - unread buffer keeps interrupt asserted
// - missing stop bit flags framing error
// - empty shifter loads holding byte, sends frame
// - holding register free once shifter loaded
// - tx control: parity select, completion status
// - tx irq on empty or complete
// - empty irq needs one priming write
// - status read clears all but empty
// - interrupt entry clears nothing
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_rx_tx (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_serial_in,
  output logic             tx_serial_out,
  output logic             irq
);

  typedef struct packed {
    logic                      aw_got;
    logic [7:0]                aw_addr;
    logic                      w_got;
    logic [7:0]                w_data;
    logic [7:0]                w_hi;
    logic [3:0]                w_strb;
    logic                      bvalid;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic [1:0]                bresp;
    logic [15:0]               baud_div;
    logic [15:0]               baud_cnt;
    uart_pkg::frame_cfg_type   rx_cfg;
    uart_pkg::frame_cfg_type   tx_cfg;
    uart_pkg::frame_state_type rx_state;
    logic [2:0]                rx_tick;
    logic [2:0]                rx_bit;
    logic [7:0]                rx_shift;
    logic                      rx_par;
    logic [7:0]                rx_buf;
    logic                      rx_full;
    logic                      rx_par_err;
    logic                      rx_frame_err;
    logic                      rx_overrun;
    uart_pkg::frame_state_type tx_state;
    logic [2:0]                tx_tick;
    logic [2:0]                tx_bit;
    logic [7:0]                tx_shift;
    logic                      tx_par;
    logic [7:0]                tx_hold;
    logic                      tx_empty;
    logic                      tx_primed;
    logic                      tx_done;
    logic                      tx_line;
    logic [1:0]                irq_stat;
    logic [1:0]                irq_mask;
  } state_type;

  state_type st_r;
  state_type st_nxt;
  logic      rx_pin;
  logic      tick;
  logic      wr_fire;
  logic      rd_fire;
  logic [7:0] ra;
  logic      rx_src;
  logic      tx_src;

  // line input is asynchronous to aclk
  sync2 u_rx_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (rx_serial_in),
    .dout    (rx_pin)
  );

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign tx_serial_out = st_r.tx_line;
  assign tick          = (st_r.baud_cnt == 16'h0000);
  assign wr_fire       = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_fire       = s_axi_arvalid && !st_r.rvalid;
  assign ra            = s_axi_araddr;
  assign irq           = |(st_r.irq_stat & st_r.irq_mask);
  // irq level sources; they stay high until firmware clears the cause
  assign rx_src = st_r.rx_cfg.enable && st_r.rx_full;
  assign tx_src = st_r.tx_cfg.enable && (st_r.tx_cfg.irq_src ? st_r.tx_done
                  : (st_r.tx_empty && st_r.tx_primed));

  always_comb begin
    st_nxt = st_r;
    // baud tick generator; one tick is one eighth of a bit period
    if (tick) begin
      st_nxt.baud_cnt = st_r.baud_div;
    end else begin
      st_nxt.baud_cnt = st_r.baud_cnt - 16'h0001;
    end

    // read clears go first, so a hardware set in the same cycle wins
    if (rd_fire && ra == `RX_CTRL_OFS) begin
      // only the error flags clear; buffer full waits for a data read
      st_nxt.rx_par_err   = 1'b0;
      st_nxt.rx_frame_err = 1'b0;
      st_nxt.rx_overrun   = 1'b0;
    end
    if (rd_fire && ra == `RX_DATA_OFS) begin
      st_nxt.rx_full = 1'b0;
    end
    if (rd_fire && ra == `TX_CTRL_OFS) begin
      st_nxt.tx_done = 1'b0;
    end

    // ---------------- axi4-lite write side
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_hi   = s_axi_wdata[15:8];
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // ---------------- receiver
    if (tick && st_r.rx_cfg.enable) begin
      st_nxt.rx_tick = st_r.rx_tick + 3'h1;
      case (st_r.rx_state)
        uart_pkg::ST_IDLE: begin
          st_nxt.rx_tick = 3'h0;
          if (!rx_pin) begin
            st_nxt.rx_state = uart_pkg::ST_START;
          end
        end
        uart_pkg::ST_START: begin
          // the start bit must still be low at mid-bit, otherwise it was a glitch
          if (st_r.rx_tick == `SAMPLE_TICK) begin
            if (rx_pin) begin
              st_nxt.rx_state = uart_pkg::ST_IDLE;
            end
          end
          if (st_r.rx_tick == `TICKS_PER_BIT) begin
            st_nxt.rx_state = uart_pkg::ST_DATA;
            st_nxt.rx_bit   = 3'h0;
            st_nxt.rx_par   = st_r.rx_cfg.par_odd;
          end
        end
        uart_pkg::ST_DATA: begin
          if (st_r.rx_tick == `SAMPLE_TICK) begin
            st_nxt.rx_shift = {rx_pin, st_r.rx_shift[7:1]};
            st_nxt.rx_par   = st_r.rx_par ^ rx_pin;
          end
          if (st_r.rx_tick == `TICKS_PER_BIT) begin
            st_nxt.rx_bit = st_r.rx_bit + 3'h1;
            if (st_r.rx_bit == 3'h7) begin
              st_nxt.rx_state = st_r.rx_cfg.par_en ? uart_pkg::ST_PARITY
                                                   : uart_pkg::ST_STOP;
            end
          end
        end
        uart_pkg::ST_PARITY: begin
          if (st_r.rx_tick == `SAMPLE_TICK && (st_r.rx_par ^ rx_pin)) begin
            st_nxt.rx_par_err = 1'b1;
          end
          if (st_r.rx_tick == `TICKS_PER_BIT) begin
            st_nxt.rx_state = uart_pkg::ST_STOP;
          end
        end
        default: begin
          // stop bit is judged at mid-bit so a following start edge is not missed
          if (st_r.rx_tick == `SAMPLE_TICK) begin
            st_nxt.rx_state = uart_pkg::ST_IDLE;
            if (!rx_pin) begin
              // low line here is taken as a new start on the next tick
              st_nxt.rx_frame_err = 1'b1;
            end
            if (st_r.rx_full) begin
              st_nxt.rx_overrun = 1'b1;
            end
            st_nxt.rx_buf  = st_r.rx_shift;
            st_nxt.rx_full = 1'b1;
          end
        end
      endcase
    end
    if (!st_r.rx_cfg.enable) begin
      st_nxt.rx_state = uart_pkg::ST_IDLE;
    end

    // transmitter; the rx pin is never looked at here
    if (tick && st_r.tx_cfg.enable) begin
      st_nxt.tx_tick = st_r.tx_tick + 3'h1;
      case (st_r.tx_state)
        uart_pkg::ST_IDLE: begin
          st_nxt.tx_tick = 3'h0;
          st_nxt.tx_line = 1'b1;
          if (!st_r.tx_empty) begin
            st_nxt.tx_shift = st_r.tx_hold;
            st_nxt.tx_empty = 1'b1;
            st_nxt.tx_par   = st_r.tx_cfg.par_odd ^ (^st_r.tx_hold);
            st_nxt.tx_line  = 1'b0;
            st_nxt.tx_state = uart_pkg::ST_START;
          end
        end
        uart_pkg::ST_START: begin
          if (st_r.tx_tick == `TICKS_PER_BIT) begin
            st_nxt.tx_state = uart_pkg::ST_DATA;
            st_nxt.tx_bit   = 3'h0;
            st_nxt.tx_line  = st_r.tx_shift[0];
          end
        end
        uart_pkg::ST_DATA: begin
          if (st_r.tx_tick == `TICKS_PER_BIT) begin
            st_nxt.tx_bit   = st_r.tx_bit + 3'h1;
            st_nxt.tx_shift = {1'b0, st_r.tx_shift[7:1]};
            st_nxt.tx_line  = st_r.tx_shift[1];
            if (st_r.tx_bit == 3'h7) begin
              st_nxt.tx_state = st_r.tx_cfg.par_en ? uart_pkg::ST_PARITY
                                                   : uart_pkg::ST_STOP;
              st_nxt.tx_line  = st_r.tx_cfg.par_en ? st_r.tx_par : 1'b1;
            end
          end
        end
        uart_pkg::ST_PARITY: begin
          if (st_r.tx_tick == `TICKS_PER_BIT) begin
            st_nxt.tx_state = uart_pkg::ST_STOP;
            st_nxt.tx_line  = 1'b1;
          end
        end
        default: begin
          // complete only after the full stop bit has left the pin
          if (st_r.tx_tick == `TICKS_PER_BIT) begin
            st_nxt.tx_state = uart_pkg::ST_IDLE;
            st_nxt.tx_done  = 1'b1;
          end
        end
      endcase
    end
    if (!st_r.tx_cfg.enable) begin
      st_nxt.tx_state = uart_pkg::ST_IDLE;
      st_nxt.tx_line  = 1'b1;
    end

    // ---------------- register reads; their clears are applied near the top, except the irq status clear below
    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = 2'b00;
      st_nxt.rdata  = 32'h0000_0000;
      if (ra == `RX_CTRL_OFS) begin
        st_nxt.rdata[`CTL_ENABLE_BIT]   = st_r.rx_cfg.enable;
        st_nxt.rdata[`CTL_PAR_EN_BIT]   = st_r.rx_cfg.par_en;
        st_nxt.rdata[`CTL_PAR_ODD_BIT]  = st_r.rx_cfg.par_odd;
        st_nxt.rdata[`RX_FULL_BIT]      = st_r.rx_full;
        st_nxt.rdata[`RX_PAR_ERR_BIT]   = st_r.rx_par_err;
        st_nxt.rdata[`RX_FRAME_ERR_BIT] = st_r.rx_frame_err;
        st_nxt.rdata[`RX_OVERRUN_BIT]   = st_r.rx_overrun;
      end else if (ra == `RX_DATA_OFS) begin
        st_nxt.rdata[7:0] = st_r.rx_buf;
      end else if (ra == `TX_CTRL_OFS) begin
        st_nxt.rdata[`CTL_ENABLE_BIT]  = st_r.tx_cfg.enable;
        st_nxt.rdata[`CTL_PAR_EN_BIT]  = st_r.tx_cfg.par_en;
        st_nxt.rdata[`CTL_PAR_ODD_BIT] = st_r.tx_cfg.par_odd;
        st_nxt.rdata[`CTL_IRQ_SRC_BIT] = st_r.tx_cfg.irq_src;
        st_nxt.rdata[`TX_EMPTY_BIT]    = st_r.tx_empty;
        st_nxt.rdata[`TX_DONE_BIT]     = st_r.tx_done;
      end else if (ra == `TX_DATA_OFS) begin
        st_nxt.rdata[7:0] = st_r.tx_hold;
      end else if (ra == `IRQ_STATUS_OFS) begin
        st_nxt.rdata[1:0] = st_r.irq_stat;
        st_nxt.irq_stat   = 2'b00;
      end else if (ra == `IRQ_MASK_OFS) begin
        st_nxt.rdata[1:0] = st_r.irq_mask;
      end else if (ra == `BAUD_DIV_OFS) begin
        st_nxt.rdata[15:0] = st_r.baud_div;
      end else begin
        st_nxt.rresp = 2'b10;
      end
    end

    // ---------------- register writes
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'b00;
      if (st_r.aw_addr == `RX_CTRL_OFS) begin
        if (st_r.w_strb[0]) begin
          st_nxt.rx_cfg.enable  = st_r.w_data[`CTL_ENABLE_BIT];
          st_nxt.rx_cfg.par_en  = st_r.w_data[`CTL_PAR_EN_BIT];
          st_nxt.rx_cfg.par_odd = st_r.w_data[`CTL_PAR_ODD_BIT];
        end
      end else if (st_r.aw_addr == `TX_CTRL_OFS) begin
        if (st_r.w_strb[0]) begin
          st_nxt.tx_cfg.enable  = st_r.w_data[`CTL_ENABLE_BIT];
          st_nxt.tx_cfg.par_en  = st_r.w_data[`CTL_PAR_EN_BIT];
          st_nxt.tx_cfg.par_odd = st_r.w_data[`CTL_PAR_ODD_BIT];
          st_nxt.tx_cfg.irq_src = st_r.w_data[`CTL_IRQ_SRC_BIT];
        end
      end else if (st_r.aw_addr == `TX_DATA_OFS) begin
        // a write while full overwrites the waiting byte
        if (st_r.w_strb[0]) begin
          st_nxt.tx_hold   = st_r.w_data;
          st_nxt.tx_empty  = 1'b0;
          st_nxt.tx_primed = 1'b1;
        end
      end else if (st_r.aw_addr == `IRQ_MASK_OFS) begin
        if (st_r.w_strb[0]) begin
          st_nxt.irq_mask = st_r.w_data[1:0];
        end
      end else if (st_r.aw_addr == `BAUD_DIV_OFS) begin
        if (st_r.w_strb[0]) begin
          st_nxt.baud_div[7:0] = st_r.w_data;
        end
        if (st_r.w_strb[1]) begin
          st_nxt.baud_div[15:8] = st_r.w_hi;
        end
      end else if (st_r.aw_addr == `RX_DATA_OFS || st_r.aw_addr == `IRQ_STATUS_OFS) begin
        st_nxt.bresp = 2'b00;
      end else begin
        st_nxt.bresp = 2'b10;
      end
    end

    // sticky interrupt status; a set wins over the read clear above
    if (rx_src) begin
      st_nxt.irq_stat[`IRQ_RX_BIT] = 1'b1;
    end
    if (tx_src) begin
      st_nxt.irq_stat[`IRQ_TX_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.baud_div <= `BAUD_DIV_RESET;
      st_r.rx_state <= uart_pkg::ST_IDLE;
      st_r.tx_state <= uart_pkg::ST_IDLE;
      st_r.tx_empty <= 1'b1;
      st_r.tx_line  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // uart_rx_tx

// ---- tb/uart_rx_tx_sva.sv ----
// checker on the bus ports and the tx serial output of the uart block
`timescale 1ns/1ps
module uart_rx_tx_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_serial_out,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer:
    assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_rd_answer:
    assert property (rd_taken |=> s_axi_rvalid) else $error("read answer late");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  a_ar_block:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_aw_block:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
  // a start bit spans eight ticks, and a tick is never shorter than one clock
  a_start_width:
    assert property ($fell(tx_serial_out) |-> !tx_serial_out [*8]) else $error("start too short");
  a_reset_idle:
    assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
      && tx_serial_out && !irq) else $error("outputs not idle after reset");
endmodule // uart_rx_tx_sva

// ---- tb/uart_line_partner.sv ----
// line model of the remote serial transceiver
`timescale 1ns/1ps
module uart_line_partner #(
  parameter int BIT_CYC = 8
) (
  input  wire logic aclk,
  input  wire logic tx_serial_out,
  output logic      rx_serial_in
);
  initial rx_serial_in = 1'b1;
  // stp low drives the stop bit low, to provoke a framing error
  task automatic send(input logic [7:0] d, input logic pe, input logic odd, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, d, 1'b0};
    if (pe) f = {stp, ^d ^ odd, d, 1'b0};
    for (int i = 0; i < (pe ? 11 : 10); i++) begin
      rx_serial_in <= f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
    rx_serial_in <= 1'b1;
  endtask
  // samples mid-bit on falling edges to stay clear of the launching edge
  task automatic recv(output logic [9:0] f, output logic ok);
    ok = 1'b0;
    for (int t = 0; t < 3000 && !ok; t++) begin
      @(negedge aclk);
      ok = !tx_serial_out;
    end
    repeat (BIT_CYC / 2) @(negedge aclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(negedge aclk);
      f[i] = tx_serial_out;
    end
  endtask
endmodule // uart_line_partner

// ---- tb/uart_rx_tx_tb_top.sv ----
// self-checking bench for the uart block
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_rx_tx_tb_top;
  typedef struct packed {logic [7:0] d; logic [2:0] cfg; logic sodd;} row_type;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        rx_serial_in;
  logic        tx_serial_out;
  logic        irq;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [31:0] rd = 32'h0;
  logic [1:0]  rsp;
  logic [9:0]  f0;
  logic [9:0]  f1;
  logic        ok0;
  logic        ok1;
  logic        perr;
  row_type     rows [4] = '{'{8'hA5, 3'h1, 1'b0}, '{8'h3C, 3'h3, 1'b0},
                            '{8'h81, 3'h7, 1'b1}, '{8'h7E, 3'h3, 1'b1}};
  always #12.5 aclk = ~aclk;
  uart_rx_tx uart_rx_tx_i (.*);
  uart_line_partner uart_line_partner_i (.*);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // pin values are copied when the task is called and compared at the next falling edge
  task automatic chk_b(input logic g, input logic e);
    @(negedge aclk);
    chk_w({31'h0, g}, {31'h0, e});
    @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic bv;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bv) begin
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        return;
      end
    end
    error_cnt++;
    give_verdict();
  endtask
  task automatic axr(input logic [7:0] a);
    logic ta;
    logic rv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        return;
      end
    end
    error_cnt++;
    give_verdict();
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk_w(rd, e);
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(`BAUD_DIV_OFS, 32'h14);
    axw(`BAUD_DIV_OFS, 32'h0);
    axw(`IRQ_MASK_OFS, 32'h3);
    foreach (rows[i]) begin
      axw(`RX_CTRL_OFS, {29'h0, rows[i].cfg});
      uart_line_partner_i.send(rows[i].d, rows[i].cfg[1], rows[i].sodd, 1'b1);
      repeat (4) @(posedge aclk);
      chk_b(irq, 1'b1);
      perr = rows[i].cfg[1] && (rows[i].sodd != rows[i].cfg[2]);
      rdchk(`RX_CTRL_OFS, {26'h0, perr, 2'b10, rows[i].cfg});
      rdchk(`RX_CTRL_OFS, {27'h0, 2'b10, rows[i].cfg});
      axr(`IRQ_STATUS_OFS);
      chk_b(irq, 1'b1);
      rdchk(`RX_DATA_OFS, {24'h0, rows[i].d});
      axr(`IRQ_STATUS_OFS);
      chk_b(irq, 1'b0);
      rdchk(`RX_CTRL_OFS, {29'h0, rows[i].cfg});
      $display("rx row %0d done", i);
    end
    axw(`RX_CTRL_OFS, 32'h1);
    uart_line_partner_i.send(8'h55, 1'b0, 1'b0, 1'b0);
    repeat (100) @(posedge aclk);
    axr(`RX_CTRL_OFS);
    chk_w(rd & 32'h50, 32'h50);
    axw(`RX_CTRL_OFS, 32'h0);
    axr(`RX_DATA_OFS);
    axr(`IRQ_STATUS_OFS);
    $display("framing test done");
    axw(`TX_CTRL_OFS, 32'h7);
    chk_b(irq, 1'b0);
    fork
      begin
        uart_line_partner_i.recv(f0, ok0);
        uart_line_partner_i.recv(f1, ok1);
      end
      begin
        axw(`TX_DATA_OFS, 32'h5A);
        for (int n = 0; n < 20 && rd[4] !== 1'b1; n++) axr(`TX_CTRL_OFS);
        chk_b(rd[4], 1'b1);
        axw(`TX_DATA_OFS, 32'hC3);
      end
    join
    chk_w({f0, ok0}, {1'b1, ~^8'h5A, 8'h5A, 1'b1});
    chk_w({f1, ok1}, {1'b1, ~^8'hC3, 8'hC3, 1'b1});
    repeat (8) @(posedge aclk);
    chk_b(irq, 1'b1);
    rdchk(`TX_CTRL_OFS, 32'h37);
    rdchk(`TX_CTRL_OFS, 32'h17);
    axw(`TX_CTRL_OFS, 32'hF);
    axr(`IRQ_STATUS_OFS);
    chk_b(irq, 1'b0);
    fork
      uart_line_partner_i.recv(f0, ok0);
      axw(`TX_DATA_OFS, 32'h0);
    join
    repeat (8) @(posedge aclk);
    chk_b(irq, 1'b1);
    chk_w({f0, ok0}, {1'b1, 1'b1, 8'h00, 1'b1});
    rdchk(`TX_CTRL_OFS, 32'h3F);
    axr(`IRQ_STATUS_OFS);
    chk_b(irq, 1'b0);
    $display("tx test done");
    rdchk(8'h1C, 32'h0);
    chk_w({30'h0, rsp}, 32'h2);
    axw(`TX_DATA_OFS, 32'hFF);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk_b(tx_serial_out, 1'b1);
    chk_b(irq, 1'b0);
    rdchk(`BAUD_DIV_OFS, 32'h14);
    $display("reset test done");
    give_verdict();
  end
endmodule // uart_rx_tx_tb_top
bind uart_rx_tx uart_rx_tx_sva uart_rx_tx_sva_i (.*);
